// *** rtl/hci_uart_pkg.sv ***
// Purpose: Shared constants and carriers for the host-facing HCI UART.
// Assumes: One 125 MHz system clock; the UART clock is a fractional enable.
// Notes:   Register offsets are byte addresses on the plain register port.
package hci_uart_pkg;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_DIVISOR = 8'h04;
    localparam logic [ADDR_W-1:0] REG_ADJUST  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_TXDATA  = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_RXDATA  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h14;
    localparam logic [ADDR_W-1:0] REG_RXLEVEL = 8'h18;
    localparam logic [ADDR_W-1:0] REG_TXLEVEL = 8'h1C;

    localparam int CTRL_CLK48_BIT    = 0;
    localparam int CTRL_HIGHRATE_BIT = 1;

    localparam int STAT_TX_FULL   = 0;
    localparam int STAT_TX_EMPTY  = 1;
    localparam int STAT_RX_FULL   = 2;
    localparam int STAT_RX_EMPTY  = 3;
    localparam int STAT_RX_OVR    = 4;
    localparam int STAT_FRAME_ERR = 5;
    localparam int STAT_TX_OVR    = 6;
    localparam int STAT_BOOT      = 7;
    localparam int STAT_TX_BUSY   = 8;

    // ------------------------------------------------------------
    // Reset values: 115.2 kbaud from a 24 MHz UART clock
    // ------------------------------------------------------------
    localparam logic [7:0] DIVISOR_RST  = 8'hF3;
    localparam logic [7:0] ADJUST_RST   = 8'h00;
    localparam logic       CLK48_RST    = 1'b0;
    localparam logic       HIGHRATE_RST = 1'b0;

    // ------------------------------------------------------------
    // Clocking and bit timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ     = 125;
    localparam int UART_CLK_LO_MHZ = 24;
    localparam int UART_CLK_HI_MHZ = 48;
    localparam int BOOT_MAX_KBPS   = 750;
    // Least bit period during boot, rounded up to whole UART clocks
    localparam int BOOT_MIN_LO     = (UART_CLK_LO_MHZ * 1000 + BOOT_MAX_KBPS - 1) / BOOT_MAX_KBPS;
    localparam int BOOT_MIN_HI     = (UART_CLK_HI_MHZ * 1000 + BOOT_MAX_KBPS - 1) / BOOT_MAX_KBPS;
    localparam int DIV_SPAN        = 256;
    localparam int OVERSAMPLE_SH   = 4;
    localparam logic [3:0] ADJ_MAX = 4'h8;
    localparam int BITLEN_W        = 13;
    localparam int ACC_W           = 8;
    localparam int DATA_BITS       = 8;

    // ------------------------------------------------------------
    // Buffers and flow control
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 1040;
    localparam int RTS_MARGIN = 16;

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic              wrEn;
        logic              rdEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } regReq_t;

    typedef struct packed {
        logic rxd;
        logic ctsN;
    } serialIn_t;

    typedef struct packed {
        logic txd;
        logic rtsN;
    } serialOut_t;

    typedef enum logic [3:0] {
        PH_IDLE  = 4'b0001,
        PH_START = 4'b0010,
        PH_DATA  = 4'b0100,
        PH_STOP  = 4'b1000
    } phase_t;

endpackage

// *** rtl/byte_fifo.sv ***
// Purpose: Synchronous FIFO with valid/ready on both sides and a fill level.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Depth need not be a power of two; pointers wrap explicitly.
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 1040
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         inValid,
    input  wire logic [WIDTH-1:0]             inData,
    output logic                              inReady,
    output logic                              outValid,
    output logic [WIDTH-1:0]                  outData,
    input  wire logic                         outReady,
    output logic [$clog2(DEPTH+1)-1:0]        level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [CW-1:0] count;
    } fifoState_t;

    fifoState_t st_r;
    fifoState_t st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign inReady  = (st_r.count != FULL);
    assign outValid = (st_r.count != '0);
    assign outData  = mem[st_r.rdPtr];
    assign level    = st_r.count;
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wrPtr = (st_r.wrPtr == LAST) ? '0 : st_r.wrPtr + PW'(1);
        end
        if (pop) begin
            st_nxt.rdPtr = (st_r.rdPtr == LAST) ? '0 : st_r.rdPtr + PW'(1);
        end
        if (push && !pop) begin
            st_nxt.count = st_r.count + CW'(1);
        end else if (pop && !push) begin
            st_nxt.count = st_r.count - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_r.wrPtr] <= inData;
        end
    end
endmodule

// *** rtl/hci_uart.sv ***
// Purpose: Host-facing four-wire HCI UART with fractional baud generator.
// Assumes: All pins synchronous to clk; firmware relays the host's baud change
//          command into the divisor, adjust and control registers.
// Notes:   Bytes pass transparently; H4 packet parsing is left to firmware.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps

// What this block does
// R1 - The link uses receive, transmit, request-to-send and clear-to-send lines at 9600 bps up to 6 Mbps.
// R2 - While boot runs the bit rate is held at or below 750 kbps.
// R3 - A host vendor command makes firmware reprogram the baud generator registers.
// R4 - Received and outgoing bytes each have their own 1040-byte FIFO.
// R5 - Traffic in both directions follows the H4 packet framing; this block passes bytes transparently and leaves H4 parsing to firmware.
// R6 - Out of reset the link runs at 115.2 kbaud.
// R7 - The UART clock defaults to 24 MHz and may be switched to 48 MHz for rates up to 6 Mbps.
// R8 - The divisor value divides the UART clock by an integer multiple of 16 for the base bit period.
// R9 - The adjust value stuffs up to eight clocks in the first half and up to eight at the end of each bit.
// R10 - At 24 MHz high-rate mode gives 3 Mbps with FF/F8 and 2 Mbps with FF/F4.
// R11 - At 48 MHz high-rate gives 6M and 4M, and normal mode with 01/E6 gives 115200 bps.
// R12 - The combined rate error of both ends must stay within 2.5 percent.
// R13 - After reset the rate comes from a configuration record and the host command may rewrite it.
// R14 - Request-to-send drops when the receive buffer nears full, and no character starts while clear-to-send is off.
// R15 - Characters are one start bit, eight data bits LSB first, no parity, one stop bit.
module hci_uart
    import hci_uart_pkg::*;
#(
    parameter int DEPTH  = FIFO_DEPTH,
    parameter int MARGIN = RTS_MARGIN
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire regReq_t           regReq,
    output logic [DATA_W-1:0]      rdData,
    input  wire serialIn_t         serIn,
    output serialOut_t             serOut,
    input  wire logic              bootActive
);
    localparam int LW = $clog2(DEPTH + 1);
    localparam logic [LW-1:0] RTS_LEVEL = LW'(DEPTH - MARGIN);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                clk48;
        logic                highRate;
        logic [7:0]          divisor;
        logic [7:0]          adjust;
        logic [ACC_W-1:0]    acc;
        logic                tick;
        phase_t              txPh;
        logic [BITLEN_W-1:0] txCnt;
        logic [2:0]          txBit;
        logic [7:0]          txShift;
        logic                txd;
        phase_t              rxPh;
        logic [BITLEN_W-1:0] rxCnt;
        logic [2:0]          rxBit;
        logic [7:0]          rxShift;
        logic                rxPush;
        logic                rtsN;
        logic                rxOvr;
        logic                frameErr;
        logic                txOvr;
        logic [DATA_W-1:0]   rdData;
    } uartState_t;

    uartState_t st_r;
    uartState_t st_nxt;

    logic            txInValid;
    logic            txInReady;
    logic            txOutValid;
    logic [7:0]      txOutData;
    logic            txPop;
    logic [LW-1:0]   txLevel;
    logic            rxInReady;
    logic            rxOutValid;
    logic [7:0]      rxOutData;
    logic            rxPop;
    logic [LW-1:0]   rxLevel;

    logic [BITLEN_W-1:0] baseLen;
    logic [BITLEN_W-1:0] rawLen;
    logic [BITLEN_W-1:0] bitLen;
    logic [BITLEN_W-1:0] bootMin;
    logic [BITLEN_W-1:0] halfPoint;
    logic [3:0]          adjFirst;
    logic [3:0]          adjEnd;
    logic [8:0]          span;
    logic [ACC_W:0]      accSum;
    logic [DATA_W-1:0]   status;
    logic [DATA_W-1:0]   readVal;

    // ------------------------------------------------------------
    // Buffers
    // ------------------------------------------------------------
    assign txInValid = regReq.wrEn && (regReq.addr == REG_TXDATA); // R5
    assign rxPop     = regReq.rdEn && (regReq.addr == REG_RXDATA) && rxOutValid;

    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txFifo ( // R4
        .clk      (clk),
        .rst      (rst),
        .inValid  (txInValid),
        .inData   (regReq.wrData[7:0]),
        .inReady  (txInReady),
        .outValid (txOutValid),
        .outData  (txOutData),
        .outReady (txPop),
        .level    (txLevel)
    );

    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxFifo ( // R4
        .clk      (clk),
        .rst      (rst),
        .inValid  (st_r.rxPush),
        .inData   (st_r.rxShift),
        .inReady  (rxInReady),
        .outValid (rxOutValid),
        .outData  (rxOutData),
        .outReady (rxPop),
        .level    (rxLevel)
    );

    // ------------------------------------------------------------
    // Bit period arithmetic
    // ------------------------------------------------------------
    always_comb begin
        span     = 9'(DIV_SPAN) - {1'b0, st_r.divisor};
        adjFirst = (st_r.adjust[7:4] > ADJ_MAX) ? ADJ_MAX : st_r.adjust[7:4]; // R9
        adjEnd   = (st_r.adjust[3:0] > ADJ_MAX) ? ADJ_MAX : st_r.adjust[3:0]; // R9
        if (st_r.highRate) begin
            // High-rate mode counts UART clocks directly and ignores stuffing
            baseLen   = BITLEN_W'(span); // R10 R11
            rawLen    = baseLen;
            halfPoint = baseLen >> 1;
        end else begin
            baseLen   = BITLEN_W'(span) << OVERSAMPLE_SH; // R8
            rawLen    = baseLen + BITLEN_W'(adjFirst) + BITLEN_W'(adjEnd); // R9 R11
            halfPoint = (baseLen >> 1) + BITLEN_W'(adjFirst);
        end
        bootMin = st_r.clk48 ? BITLEN_W'(BOOT_MIN_HI) : BITLEN_W'(BOOT_MIN_LO);
        // Slower of programmed and boot ceiling while boot runs
        bitLen  = (bootActive && rawLen < bootMin) ? bootMin : rawLen; // R2
        if (bootActive && rawLen < bootMin) begin
            halfPoint = bootMin >> 1;
        end
        accSum = {1'b0, st_r.acc} + (st_r.clk48 ? (ACC_W+1)'(UART_CLK_HI_MHZ) // R7 R12
                                                : (ACC_W+1)'(UART_CLK_LO_MHZ));
    end

    assign txPop = st_r.txPh[0] && txOutValid && !serIn.ctsN; // R14

    // ------------------------------------------------------------
    // Register read view
    // ------------------------------------------------------------
    always_comb begin
        status                 = '0;
        status[STAT_TX_FULL]   = !txInReady;
        status[STAT_TX_EMPTY]  = !txOutValid;
        status[STAT_RX_FULL]   = !rxInReady;
        status[STAT_RX_EMPTY]  = !rxOutValid;
        status[STAT_RX_OVR]    = st_r.rxOvr;
        status[STAT_FRAME_ERR] = st_r.frameErr;
        status[STAT_TX_OVR]    = st_r.txOvr;
        status[STAT_BOOT]      = bootActive;
        status[STAT_TX_BUSY]   = !st_r.txPh[0];
        case (regReq.addr)
            REG_CTRL: begin
                readVal                    = '0;
                readVal[CTRL_CLK48_BIT]    = st_r.clk48;
                readVal[CTRL_HIGHRATE_BIT] = st_r.highRate;
            end
            REG_DIVISOR: readVal = DATA_W'(st_r.divisor);
            REG_ADJUST:  readVal = DATA_W'(st_r.adjust);
            REG_RXDATA:  readVal = rxOutValid ? DATA_W'(rxOutData) : '0;
            REG_STATUS:  readVal = status;
            REG_RXLEVEL: readVal = DATA_W'(rxLevel);
            REG_TXLEVEL: readVal = DATA_W'(txLevel);
            default:     readVal = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rxPush = 1'b0;
        st_nxt.rdData = regReq.rdEn ? readVal : '0;

        // Configuration, rewritten by firmware on the host's rate command
        if (regReq.wrEn) begin
            case (regReq.addr)
                REG_CTRL: begin
                    st_nxt.clk48    = regReq.wrData[CTRL_CLK48_BIT]; // R7 R3
                    st_nxt.highRate = regReq.wrData[CTRL_HIGHRATE_BIT]; // R3
                end
                REG_DIVISOR: st_nxt.divisor = regReq.wrData[7:0]; // R3 R13
                REG_ADJUST:  st_nxt.adjust  = regReq.wrData[7:0]; // R3 R13
                REG_STATUS: begin
                    if (regReq.wrData[STAT_RX_OVR]) begin
                        st_nxt.rxOvr = 1'b0;
                    end
                    if (regReq.wrData[STAT_FRAME_ERR]) begin
                        st_nxt.frameErr = 1'b0;
                    end
                    if (regReq.wrData[STAT_TX_OVR]) begin
                        st_nxt.txOvr = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Sets below win over a clear in the same cycle
        if (txInValid && !txInReady) begin
            st_nxt.txOvr = 1'b1;
        end

        // Fractional UART clock enable: 24 or 48 per 125 system clocks
        if (accSum >= (ACC_W+1)'(SYS_CLK_MHZ)) begin
            st_nxt.acc  = ACC_W'(accSum - (ACC_W+1)'(SYS_CLK_MHZ));
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.acc  = ACC_W'(accSum);
            st_nxt.tick = 1'b0;
        end

        // Transmitter
        case (st_r.txPh)
            PH_IDLE: begin
                st_nxt.txd = 1'b1;
                if (txPop) begin // R14
                    st_nxt.txShift = txOutData;
                    st_nxt.txPh    = PH_START;
                    st_nxt.txCnt   = '0;
                    st_nxt.txd     = 1'b0; // R15
                end
            end
            PH_START, PH_DATA, PH_STOP: begin
                if (st_r.tick) begin
                    if (st_r.txCnt >= bitLen - BITLEN_W'(1)) begin
                        st_nxt.txCnt = '0;
                        if (st_r.txPh == PH_START) begin
                            st_nxt.txPh  = PH_DATA;
                            st_nxt.txBit = '0;
                            st_nxt.txd   = st_r.txShift[0]; // R15
                        end else if (st_r.txPh == PH_DATA) begin
                            if (st_r.txBit == 3'(DATA_BITS - 1)) begin
                                st_nxt.txPh = PH_STOP;
                                st_nxt.txd  = 1'b1; // R15
                            end else begin
                                st_nxt.txBit   = st_r.txBit + 3'd1;
                                st_nxt.txShift = {1'b0, st_r.txShift[7:1]};
                                st_nxt.txd     = st_r.txShift[1];
                            end
                        end else begin
                            st_nxt.txPh = PH_IDLE;
                        end
                    end else begin
                        st_nxt.txCnt = st_r.txCnt + BITLEN_W'(1);
                    end
                end
            end
            default: begin
                st_nxt.txPh = PH_IDLE;
                st_nxt.txd  = 1'b1;
            end
        endcase

        // Receiver: sample each bit at its stuffed midpoint
        case (st_r.rxPh)
            PH_IDLE: begin
                if (st_r.tick && !serIn.rxd) begin
                    st_nxt.rxPh  = PH_START;
                    st_nxt.rxCnt = '0;
                end
            end
            PH_START, PH_DATA, PH_STOP: begin
                if (st_r.tick) begin
                    st_nxt.rxCnt = st_r.rxCnt + BITLEN_W'(1);
                    if (st_r.rxCnt == halfPoint) begin
                        if (st_r.rxPh == PH_START) begin
                            if (serIn.rxd) begin
                                st_nxt.rxPh = PH_IDLE; // Glitch, not a start bit
                            end
                        end else if (st_r.rxPh == PH_DATA) begin
                            st_nxt.rxShift = {serIn.rxd, st_r.rxShift[7:1]}; // R15
                        end else begin
                            // Return to idle at mid stop bit to catch a close start
                            st_nxt.rxPh = PH_IDLE;
                            if (!serIn.rxd) begin
                                st_nxt.frameErr = 1'b1; // R15
                            end else if (!rxInReady) begin
                                st_nxt.rxOvr = 1'b1;
                            end else begin
                                st_nxt.rxPush = 1'b1; // R4
                            end
                        end
                    end
                    if (st_r.rxCnt >= bitLen - BITLEN_W'(1)) begin
                        st_nxt.rxCnt = '0;
                        if (st_r.rxPh == PH_START) begin
                            st_nxt.rxPh  = PH_DATA;
                            st_nxt.rxBit = '0;
                        end else if (st_r.rxPh == PH_DATA) begin
                            if (st_r.rxBit == 3'(DATA_BITS - 1)) begin
                                st_nxt.rxPh = PH_STOP;
                            end else begin
                                st_nxt.rxBit = st_r.rxBit + 3'd1;
                            end
                        end
                    end
                end
            end
            default: st_nxt.rxPh = PH_IDLE;
        endcase

        // Flow control keeps a margin for bytes already in flight
        st_nxt.rtsN = (rxLevel >= RTS_LEVEL); // R14
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r          <= '0;
            st_r.clk48    <= CLK48_RST; // R6
            st_r.highRate <= HIGHRATE_RST; // R6
            st_r.divisor  <= DIVISOR_RST; // R6
            st_r.adjust   <= ADJUST_RST; // R6
            st_r.txPh     <= PH_IDLE;
            st_r.rxPh     <= PH_IDLE;
            st_r.txd      <= 1'b1;
            st_r.rtsN     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdData      = st_r.rdData;
    assign serOut.txd  = st_r.txd; // R1
    assign serOut.rtsN = st_r.rtsN; // R1
endmodule

// *** bench/hci_uart_asserts.sv ***
// Purpose: Port checks for the HCI UART.
// Assumes: Register values are shadowed from bus writes.
// Notes:   Low-run floors allow one clock of tick jitter at 6 Mbps and about six clocks under boot.
`timescale 1ns/1ps
module hci_uart_asserts
    import hci_uart_pkg::*;
#(parameter int DEPTH = FIFO_DEPTH, parameter int MARGIN = RTS_MARGIN) (
    input wire logic              clk,
    input wire logic              rst,
    input wire regReq_t           regReq,
    input wire logic [DATA_W-1:0] rdData,
    input wire serialIn_t         serIn,
    input wire serialOut_t        serOut,
    input wire logic              bootActive
);
    logic [7:0] div_r;
    logic [7:0] adj_r;
    logic [7:0] lowRun_r;
    logic       rxPop;
    assign rxPop = regReq.rdEn && regReq.addr == REG_RXDATA;
    always_ff @(posedge clk) begin
        lowRun_r <= serOut.txd ? 8'h00 : lowRun_r + {7'h00, lowRun_r != 8'hFF};
        if (rst) div_r <= DIVISOR_RST;
        else if (regReq.wrEn && regReq.addr == REG_DIVISOR) div_r <= regReq.wrData[7:0];
        if (rst) adj_r <= ADJUST_RST;
        else if (regReq.wrEn && regReq.addr == REG_ADJUST) adj_r <= regReq.wrData[7:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_idle; !$past(regReq.rdEn) |-> rdData == '0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("data outside read slot");
    property p_div_rb; regReq.rdEn && regReq.addr == REG_DIVISOR |=> rdData[7:0] == div_r; endproperty
    a_div_rb: assert property (p_div_rb) else $error("divisor readback");
    property p_adj_rb; regReq.rdEn && regReq.addr == REG_ADJUST |=> rdData[7:0] == adj_r; endproperty
    a_adj_rb: assert property (p_adj_rb) else $error("adjust readback");
    property p_unmapped; regReq.rdEn && regReq.addr > REG_TXLEVEL |=> rdData == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_boot_flag;
        regReq.rdEn && regReq.addr == REG_STATUS |=> rdData[STAT_BOOT] == $past(bootActive);
    endproperty
    a_boot_flag: assert property (p_boot_flag) else $error("boot flag");
    // A 6 Mbps bit is about 20.8 clocks, a boot-clamped bit about 166.7
    property p_max_rate; $rose(serOut.txd) |-> lowRun_r >= 8'h13; endproperty
    a_max_rate: assert property (p_max_rate) else $error("bit too short");
    property p_boot_bit; $rose(serOut.txd) && bootActive |-> lowRun_r >= 8'hA0; endproperty
    a_boot_bit: assert property (p_boot_bit) else $error("boot bit too short");
    property p_rts_fall; $fell(serOut.rtsN) |-> $past(rxPop) || $past(rxPop, 2) || $past(rxPop, 3); endproperty
    a_rts_fall: assert property (p_rts_fall) else $error("rts fell without pop");
    c_rts: cover property ($fell(serOut.rtsN));
    c_boot: cover property ($rose(serOut.txd) && bootActive);
    c_pop: cover property (rxPop);
endmodule
bind hci_uart hci_uart_asserts #(.DEPTH(DEPTH), .MARGIN(MARGIN)) u_asserts (.clk(clk), .rst(rst),
    .regReq(regReq), .rdData(rdData), .serIn(serIn), .serOut(serOut), .bootActive(bootActive));

// *** bench/host_uart_model.sv ***
// Purpose: Host-side UART model for the HCI link.
// Assumes: 8N1 framing; the bench sets the bit time.
// Notes:   Sends on clock edges; receives by mid-bit sampling.
`timescale 1ns/1ps
module host_uart_model (
    input  wire logic clk,
    input  wire logic txd,
    input  wire logic rtsN,
    output logic      rxd,
    output logic      ctsN
);
    real        bitNs = 8666.7;
    logic [7:0] got[$];
    logic [7:0] sh;
    initial {rxd, ctsN} = 2'b10;
    task automatic send(input logic [7:0] b);
        int cyc;
        cyc = int'(bitNs / 8.0 + 0.5);
        wait (rtsN === 1'b0);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (cyc - 1) @(posedge clk);
        end
    endtask
    // Mid-bit sampling rides out the fractional tick jitter
    always begin
        @(negedge txd);
        #(bitNs * 1.5);
        for (int i = 0; i < 8; i++) begin
            sh[i] = txd;
            #(bitNs);
        end
        if (txd === 1'b1) got.push_back(sh);
    end
endmodule

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the HCI UART.
// Assumes: Host model on the serial side; 8-deep FIFOs, margin 2.
// Notes:   Bit times follow from tick counts and the UART clock.
`timescale 1ns/1ps
module tb;
    import hci_uart_pkg::*;
    logic              clk, rst, bootActive, hostRxd, hostCtsN;
    logic [7:0]        b;
    logic [DATA_W-1:0] rdVal, rdData;
    regReq_t           regReq;
    serialIn_t         serIn;
    serialOut_t        serOut;
    int                nErrors = 0, checksDone = 0, cyc = 1100;
    // CTRL, DIVISOR, ADJUST and bit length in UART ticks; last entry runs under boot
    logic [7:0] cCtl[8] = '{8'h00, 8'h02, 8'h02, 8'h03, 8'h03, 8'h01, 8'h01, 8'h03};
    logic [7:0] cDiv[8] = '{8'hF3, 8'hF8, 8'hF4, 8'hF8, 8'hF4, 8'hE6, 8'hFF, 8'hF8};
    logic [7:0] cAdj[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h9F, 8'h00};
    int         ticks[8] = '{208, 8, 12, 8, 12, 417, 32, 64};
    assign serIn = '{hostRxd, hostCtsN};
    hci_uart #(.DEPTH(8), .MARGIN(2)) u_dut (.clk(clk), .rst(rst), .regReq(regReq),
        .rdData(rdData), .serIn(serIn), .serOut(serOut), .bootActive(bootActive));
    host_uart_model u_host (.clk(clk), .txd(serOut.txd), .rtsN(serOut.rtsN), .rxd(hostRxd), .ctsN(hostCtsN));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        checksDone++;
        if (g !== e) begin
            nErrors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        regReq <= '{w, !w, a, d};
        @(posedge clk);
        regReq <= '0;
        @(negedge clk);
        rdVal = rdData;
        @(posedge clk);
    endtask
    task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        bus(1'b0, a, '0);
        chk(nm, e, rdVal);
    endtask
    task automatic txchk();
        for (int k = 0; k < 12 * cyc + 64 && u_host.got.size() == 0; k++)
            @(posedge clk);
        chk("tx count", 32'h1, 32'(u_host.got.size()));
        if (u_host.got.size() > 0)
            chk("tx byte", {24'h0, b}, {24'h0, u_host.got.pop_front()});
    endtask
    initial begin
        rst = 1'b1;
        bootActive = 1'b0;
        regReq = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk("ctrl", REG_CTRL, 32'h0);
        rchk("divisor", REG_DIVISOR, 32'hF3);
        rchk("adjust", REG_ADJUST, 32'h0);
        rchk("status", REG_STATUS, 32'h0A);
        rchk("unmapped", 8'h40, 32'h0);
        for (int i = 0; i < 8; i++) begin
            bootActive <= (i == 7);
            bus(1'b1, REG_CTRL, {24'h0, cCtl[i]});
            bus(1'b1, REG_DIVISOR, {24'h0, cDiv[i]});
            bus(1'b1, REG_ADJUST, {24'h0, cAdj[i]});
            u_host.bitNs = ticks[i] * 1000.0 / (cCtl[i][0] ? UART_CLK_HI_MHZ : UART_CLK_LO_MHZ);
            cyc = int'(u_host.bitNs / 8.0) + 1;
            b = 8'h81 ^ 8'(i * 37);
            bus(1'b1, REG_TXDATA, {24'h0, b});
            txchk();
            u_host.send(~b);
            repeat (4) @(posedge clk);
            rchk("rx byte", REG_RXDATA, {24'h0, ~b});
        end
        u_host.ctsN <= 1'b1;
        b = 8'h77;
        bus(1'b1, REG_TXDATA, {24'h0, b});
        repeat (400) @(posedge clk);
        rchk("held status", REG_STATUS, 32'h88);
        rchk("tx level", REG_TXLEVEL, 32'h01);
        u_host.ctsN <= 1'b0;
        txchk();
        for (int i = 0; i < 6; i++)
            u_host.send(8'h10 + 8'(i));
        repeat (4) @(posedge clk);
        chk("rts full", 32'h1, {31'h0, serOut.rtsN});
        rchk("rx level", REG_RXLEVEL, 32'h06);
        rchk("rx head", REG_RXDATA, 32'h10);
        repeat (4) @(posedge clk);
        chk("rts free", 32'h0, {31'h0, serOut.rtsN});
        report_and_stop();
    end
    initial begin
        #700000;
        nErrors++;
        report_and_stop();
    end
endmodule
